// ---- agum_core.sv ----
//------------------------------------------------------------------------------
// Purpose : Effective address generation with circular-buffer correction for
//           one X and one Y buffer and bit-reversed X writes.
// Assumes : Decoder presents pointer, modifier and offset register values with
//           a one-cycle REQ pulse; results appear one cycle later.
// Notes   : Write-back of pointers is reported, not performed, here.
//------------------------------------------------------------------------------
`timescale 1ns/10ps

module agum_core (
  // Clock and reset
  input  wire logic                           CLK,
  input  wire logic                           RESET,
  // Register port
  input  wire logic [agum_pkg::RADR_W-1:0]    REG_ADDR,
  input  wire logic [agum_pkg::DATA_W-1:0]    REG_WDATA,
  input  wire logic                           REG_WRITE,
  input  wire logic                           REG_READ,
  output logic      [agum_pkg::DATA_W-1:0]    REG_RDATA,
  // Request, common part
  input  wire logic                           REQ,
  input  wire logic                           MAC_CLASS,
  input  wire logic [agum_pkg::DATA_W-1:0]    OFFSET_VALUE,
  // Source (read) operand
  input  wire logic                           SRC_Y_SPACE,
  input  wire agum_pkg::agum_mode_t           SRC_MODE,
  input  wire logic [agum_pkg::SEL_W-1:0]     SRC_PTR_SEL,
  input  wire logic [agum_pkg::DATA_W-1:0]    SRC_PTR_VALUE,
  input  wire logic [agum_pkg::DATA_W-1:0]    SRC_MODIFIER,
  // Destination (X write) operand
  input  wire agum_pkg::agum_mode_t           DST_MODE,
  input  wire logic [agum_pkg::SEL_W-1:0]     DST_PTR_SEL,
  input  wire logic [agum_pkg::DATA_W-1:0]    DST_PTR_VALUE,
  input  wire logic [agum_pkg::DATA_W-1:0]    DST_MODIFIER,
  input  wire logic                           DST_WORD,
  // Results
  output logic                                DONE,
  output logic      [agum_pkg::DATA_W-1:0]    SRC_EA,
  output logic                                SRC_SPACE_Y,
  output logic                                SRC_WRAPPED,
  output logic                                SRC_ILLEGAL,
  output logic                                SRC_WB_EN,
  output logic      [agum_pkg::SEL_W-1:0]     SRC_WB_SEL,
  output logic      [agum_pkg::DATA_W-1:0]    SRC_WB_VALUE,
  output logic      [agum_pkg::DATA_W-1:0]    DST_EA,
  output logic                                DST_WRAPPED,
  output logic                                DST_BITREV,
  output logic                                DST_WB_EN,
  output logic      [agum_pkg::SEL_W-1:0]     DST_WB_SEL,
  output logic      [agum_pkg::DATA_W-1:0]    DST_WB_VALUE
);
  import agum_pkg::*;

  //----------------------------------------------------------------------------
  // Functions
  //----------------------------------------------------------------------------
  // Address after the mode's step; register-offset mode uses the shared offset value, literal offset the modifier
  function automatic logic [DATA_W-1:0] step_addr(input agum_mode_t m, input logic [DATA_W-1:0] p,
                                                  input logic [DATA_W-1:0] md, input logic [DATA_W-1:0] off);
    logic [DATA_W-1:0] r;
    r = p;
    case (m)
      MODE_POSTMOD, MODE_PREMOD, MODE_LITOFF: r = p + md;
      MODE_REGOFF: r = p + off;
      default: r = p;
    endcase
    return r;
  endfunction

  // Direction of travel, taken from the sign of the step
  function automatic logic step_neg(input agum_mode_t m, input logic [DATA_W-1:0] md,
                                    input logic [DATA_W-1:0] off);
    logic n;
    n = (m == MODE_REGOFF) ? off[DATA_W-1] : md[DATA_W-1];
    return n;
  endfunction

  // Circular correction: {wrapped, corrected address}
  function automatic logic [DATA_W:0] wrap(input logic [DATA_W-1:0] a, input logic neg,
                                           input logic [DATA_W-1:0] s, input logic [DATA_W-1:0] e);
    logic [DATA_W:0] len;
    logic            pow2;
    logic            over;
    logic            under;
    len   = {1'b0, e} - {1'b0, s} + ONE17;
    pow2  = (len & (len - ONE17)) == ZERO17;
    over  = (a > e) && (!neg || pow2);
    under = (a < s) && (neg || pow2);
    if (over) begin
      return {1'b1, a - len[DATA_W-1:0]};
    end else if (under) begin
      return {1'b1, a + len[DATA_W-1:0]};
    end
    return {1'b0, a};
  endfunction

  // Bit order reversal of a word
  function automatic logic [DATA_W-1:0] rev(input logic [DATA_W-1:0] v);
    logic [DATA_W-1:0] r;
    r = ZERO16;
    for (int i = 0; i < DATA_W; i++) begin
      r[i] = v[DATA_W-1-i];
    end
    return r;
  endfunction

  //----------------------------------------------------------------------------
  // Registers
  //----------------------------------------------------------------------------
  logic [DATA_W-1:0] ctrl;
  logic [DATA_W-1:0] x_buffer_start;
  logic [DATA_W-1:0] x_buffer_end;
  logic [DATA_W-1:0] y_buffer_start;
  logic [DATA_W-1:0] y_buffer_end;
  logic [DATA_W-1:0] bitrev_ctrl;
  logic [DATA_W-1:0] next_rdata;

  // Address decode; unmapped indices read as zero
  wire hit_ctrl   = (REG_ADDR == REG_CTRL);
  wire hit_xstart = (REG_ADDR == REG_XSTART);
  wire hit_xend   = (REG_ADDR == REG_XEND);
  wire hit_ystart = (REG_ADDR == REG_YSTART);
  wire hit_yend   = (REG_ADDR == REG_YEND);
  wire hit_bitrev = (REG_ADDR == REG_BITREV);

  always_comb begin
    if (hit_ctrl) begin
      next_rdata = ctrl;
    end else if (hit_xstart) begin
      next_rdata = x_buffer_start;
    end else if (hit_xend) begin
      next_rdata = x_buffer_end;
    end else if (hit_ystart) begin
      next_rdata = y_buffer_start;
    end else if (hit_yend) begin
      next_rdata = y_buffer_end;
    end else if (hit_bitrev) begin
      next_rdata = bitrev_ctrl;
    end else begin
      next_rdata = ZERO16;
    end
  end

  // Register writes; buffer bounds have no defined reset so clear them
  always_ff @(posedge CLK) begin
    if (RESET) begin
      ctrl           <= CTRL_RESET;
      x_buffer_start <= ZERO16;
      x_buffer_end   <= ZERO16;
      y_buffer_start <= ZERO16;
      y_buffer_end   <= ZERO16;
      bitrev_ctrl    <= ZERO16;
    end else if (REG_WRITE) begin
      if (hit_ctrl)   ctrl           <= REG_WDATA;
      if (hit_xstart) x_buffer_start <= REG_WDATA;
      if (hit_xend)   x_buffer_end   <= REG_WDATA;
      if (hit_ystart) y_buffer_start <= REG_WDATA;
      if (hit_yend)   y_buffer_end   <= REG_WDATA;
      if (hit_bitrev) bitrev_ctrl    <= REG_WDATA;
    end
  end

  // Read data stands only in the cycle after the read strobe
  always_ff @(posedge CLK) begin
    if (RESET) begin
      REG_RDATA <= ZERO16;
    end else begin
      REG_RDATA <= REG_READ ? next_rdata : ZERO16;
    end
  end

  //----------------------------------------------------------------------------
  // Control fields
  //----------------------------------------------------------------------------
  wire [SEL_W-1:0] x_pointer_select  = ctrl[X_SEL_LSB +: SEL_W];
  wire [SEL_W-1:0] y_pointer_select  = ctrl[Y_SEL_LSB +: SEL_W];
  // Select 15 parks the stack pointer out of circular use
  wire             x_circular_enable = ctrl[X_EN_BIT] && (x_pointer_select != SEL_OFF);
  wire             y_circular_enable = ctrl[Y_EN_BIT] && (y_pointer_select != SEL_OFF);
  wire             bitrev_enable     = bitrev_ctrl[BREV_EN_BIT];
  wire [DATA_W-1:0] bitrev_mod       = {bitrev_ctrl[BREV_MOD_W-1:0], 1'b0};  // Word scaled

  //----------------------------------------------------------------------------
  // Source operand: X read or Y generator
  //----------------------------------------------------------------------------
  wire mac_in_set  = (SRC_PTR_SEL[SEL_W-1:2] == MAC_PTR_HI);
  // Registers 10 and 11 have bit 1 set and belong to Y space
  wire src_y       = MAC_CLASS ? SRC_PTR_SEL[1] : SRC_Y_SPACE;
  wire mac_idx_ok  = (SRC_PTR_SEL == MAC_X_IDX) || (SRC_PTR_SEL == MAC_Y_IDX);
  wire mac_step_ok = (SRC_MODIFIER == MAC_STEP2) || (SRC_MODIFIER == MAC_STEP4) ||
                     (SRC_MODIFIER == MAC_STEP6) || (-SRC_MODIFIER == MAC_STEP2) ||
                     (-SRC_MODIFIER == MAC_STEP4) || (-SRC_MODIFIER == MAC_STEP6);
  wire mac_mode_ok = (SRC_MODE == MODE_INDIRECT) ||
                     ((SRC_MODE == MODE_POSTMOD) && mac_step_ok) ||
                     ((SRC_MODE == MODE_REGOFF) && mac_idx_ok);
  wire src_illegal = MAC_CLASS && !(mac_in_set && mac_mode_ok);

  wire [DATA_W-1:0] src_sum  = step_addr(SRC_MODE, SRC_PTR_VALUE, SRC_MODIFIER, OFFSET_VALUE);
  wire              src_neg  = step_neg(SRC_MODE, SRC_MODIFIER, OFFSET_VALUE);
  wire              src_step = (SRC_MODE != MODE_INDIRECT);
  // Any pointer but 15 may be the circular one; X also covers program-space reads
  wire src_mod_on = src_step && (src_y ?
                    (y_circular_enable && (SRC_PTR_SEL == y_pointer_select)) :
                    (x_circular_enable && (SRC_PTR_SEL == x_pointer_select)));
  wire [DATA_W:0]   src_wrap = src_y ? wrap(src_sum, src_neg, y_buffer_start, y_buffer_end)
                                     : wrap(src_sum, src_neg, x_buffer_start, x_buffer_end);
  wire [DATA_W-1:0] src_fix_raw = src_mod_on ? src_wrap[DATA_W-1:0] : src_sum;
  // Y circular arithmetic is word sized
  wire [DATA_W-1:0] src_fix  = (src_mod_on && src_y) ? {src_fix_raw[DATA_W-1:1], 1'b0}
                                                     : src_fix_raw;
  // Post-modify presents the old pointer, which is word aligned as well in Y circular use
  wire [DATA_W-1:0] src_ea   = (SRC_MODE != MODE_POSTMOD) ? src_fix :
                               ((src_mod_on && src_y) ? {SRC_PTR_VALUE[DATA_W-1:1], 1'b0} : SRC_PTR_VALUE);
  wire              src_wb   = ((SRC_MODE == MODE_POSTMOD) || (SRC_MODE == MODE_PREMOD)) &&
                               !src_illegal;
  wire              src_wrp  = src_mod_on && src_wrap[DATA_W];

  //----------------------------------------------------------------------------
  // Destination operand: X write generator
  //----------------------------------------------------------------------------
  wire dst_inc = ((DST_MODE == MODE_POSTMOD) || (DST_MODE == MODE_PREMOD)) && !DST_MODIFIER[DATA_W-1];
  // Only the X write side reverses, and only for word writes
  wire dst_brev = bitrev_enable && dst_inc && DST_WORD;
  // The modifier is reversed; pointer order stays normal, so add with reversed carry
  wire [DATA_W-1:0] brev_sum = rev(rev(DST_PTR_VALUE) + rev(bitrev_mod));
  wire [DATA_W-1:0] brev_fix = {brev_sum[DATA_W-1:1], 1'b0};
  wire [DATA_W-1:0] dst_sum  = step_addr(DST_MODE, DST_PTR_VALUE, DST_MODIFIER, OFFSET_VALUE);
  wire              dst_neg  = step_neg(DST_MODE, DST_MODIFIER, OFFSET_VALUE);
  // Reversal wins; the read generator keeps its circular buffer meanwhile
  wire dst_mod_on = (DST_MODE != MODE_INDIRECT) && !dst_brev && x_circular_enable &&
                    (DST_PTR_SEL == x_pointer_select);
  wire [DATA_W:0]   dst_wrap = wrap(dst_sum, dst_neg, x_buffer_start, x_buffer_end);
  wire [DATA_W-1:0] dst_fix  = dst_brev ? brev_fix :
                               (dst_mod_on ? dst_wrap[DATA_W-1:0] : dst_sum);
  wire [DATA_W-1:0] dst_ea   = (DST_MODE == MODE_POSTMOD) ?
                               (dst_brev ? {DST_PTR_VALUE[DATA_W-1:1], 1'b0} : DST_PTR_VALUE) : dst_fix;
  wire              dst_wb   = (DST_MODE == MODE_POSTMOD) || (DST_MODE == MODE_PREMOD);
  wire              dst_wrp  = dst_mod_on && dst_wrap[DATA_W];

  //----------------------------------------------------------------------------
  // Result registers; results other than DONE and the write-back enables hold until the next request
  //----------------------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RESET) begin
      DONE         <= 1'b0;
      SRC_EA       <= ZERO16;
      SRC_SPACE_Y  <= 1'b0;
      SRC_WRAPPED  <= 1'b0;
      SRC_ILLEGAL  <= 1'b0;
      SRC_WB_EN    <= 1'b0;
      SRC_WB_SEL   <= 4'h0;
      SRC_WB_VALUE <= ZERO16;
    end else begin
      DONE <= REQ;
      SRC_WB_EN <= REQ && src_wb;
      if (REQ) begin
        SRC_EA       <= src_ea;
        SRC_SPACE_Y  <= src_y;
        SRC_WRAPPED  <= src_wrp;
        SRC_ILLEGAL  <= src_illegal;
        SRC_WB_SEL   <= SRC_PTR_SEL;
        SRC_WB_VALUE <= src_fix;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      DST_EA       <= ZERO16;
      DST_WRAPPED  <= 1'b0;
      DST_BITREV   <= 1'b0;
      DST_WB_EN    <= 1'b0;
      DST_WB_SEL   <= 4'h0;
      DST_WB_VALUE <= ZERO16;
    end else begin
      DST_WB_EN <= REQ && dst_wb;
      if (REQ) begin
        DST_EA       <= dst_ea;
        DST_WRAPPED  <= dst_wrp;
        DST_BITREV   <= dst_brev;
        DST_WB_SEL   <= DST_PTR_SEL;
        DST_WB_VALUE <= dst_fix;
      end
    end
  end

  //----------------------------------------------------------------------------
  // Assertions
  //----------------------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  a_mac_ptr_set: assert property (REQ && MAC_CLASS && !mac_in_set |=> SRC_ILLEGAL && !SRC_WB_EN)
    else $error("MAC pointer outside 8..11 accepted");
  a_mac_route: assert property (REQ && MAC_CLASS |=> SRC_SPACE_Y == $past(SRC_PTR_SEL[1]))
    else $error("MAC pointer routed to wrong space");
  a_mac_index_only: assert property (REQ && MAC_CLASS && SRC_MODE == MODE_REGOFF &&
                                     SRC_PTR_SEL == 4'h8 |=> SRC_ILLEGAL)
    else $error("MAC indexed mode accepted on register 8");
  a_mac_step_set: assert property (REQ && MAC_CLASS && mac_in_set && SRC_MODE == MODE_POSTMOD &&
                                   SRC_MODIFIER == 16'h0004 |=> !SRC_ILLEGAL ##1 !SRC_ILLEGAL || DONE)
    else $error("MAC post-modify by 4 refused");
  a_x_sel_off: assert property (REQ && x_pointer_select == SEL_OFF && !src_y |=>
                                !SRC_WRAPPED && !DST_WRAPPED)
    else $error("X correction with select 15");
  a_y_enable: assert property (REQ && src_y && !ctrl[Y_EN_BIT] |=> !SRC_WRAPPED)
    else $error("Y correction without enable");
  a_offset_no_wb: assert property (REQ && (SRC_MODE == MODE_REGOFF || SRC_MODE == MODE_LITOFF) |=>
                                   !SRC_WB_EN)
    else $error("Offset mode wrote the pointer back");
  a_y_word: assert property (DONE && SRC_WRAPPED && SRC_SPACE_Y |-> !SRC_EA[0] && !SRC_WB_VALUE[0])
    else $error("Y circular address has LSB set");
  a_brev_wins: assert property (REQ && dst_brev |=> DST_BITREV && !DST_WRAPPED)
    else $error("Circular correction applied during bit reversal");
  a_wrap_len: assert property (REQ && !src_y && src_mod_on && SRC_MODE == MODE_PREMOD &&
                               src_sum > x_buffer_end && !src_neg |=>
                               SRC_WB_VALUE == $past(src_sum - (x_buffer_end - x_buffer_start + 16'h0001)))
    else $error("Upward wrap not by buffer length");

  c_mac_wrap:   cover property (REQ && MAC_CLASS ##1 SRC_WRAPPED);
  c_bitrev:     cover property (REQ && dst_brev ##1 DST_WB_EN);
  c_indexed:    cover property (REQ && SRC_MODE == MODE_REGOFF && DST_MODE == MODE_REGOFF);
  c_down_wrap:  cover property (REQ && src_neg && src_mod_on ##1 SRC_WRAPPED);

endmodule // agum_core

// ---- agum_pkg.sv ----
//------------------------------------------------------------------------------
// Purpose : Constants and types shared by the circular / bit-reversed address
//           generator.
// Assumes : 16-bit data space, 16 working registers.
// Notes   : Register indices are word indices on the plain register port.
//------------------------------------------------------------------------------
package agum_pkg;

  //----------------------------------------------------------------------------
  // Widths
  //----------------------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int SEL_W  = 4;
  localparam int RADR_W = 3;

  //----------------------------------------------------------------------------
  // Register indices
  //----------------------------------------------------------------------------
  localparam logic [RADR_W-1:0] REG_CTRL    = 3'h0;
  localparam logic [RADR_W-1:0] REG_XSTART  = 3'h1;
  localparam logic [RADR_W-1:0] REG_XEND    = 3'h2;
  localparam logic [RADR_W-1:0] REG_YSTART  = 3'h3;
  localparam logic [RADR_W-1:0] REG_YEND    = 3'h4;
  localparam logic [RADR_W-1:0] REG_BITREV  = 3'h5;

  //----------------------------------------------------------------------------
  // Field positions and reset values
  //----------------------------------------------------------------------------
  localparam int X_SEL_LSB   = 0;
  localparam int Y_SEL_LSB   = 4;
  localparam int X_EN_BIT    = 15;
  localparam int Y_EN_BIT    = 14;
  localparam int BREV_EN_BIT = 15;
  localparam int BREV_MOD_W  = 15;
  localparam logic [SEL_W-1:0]  SEL_OFF       = 4'hF;
  localparam logic [DATA_W-1:0] CTRL_RESET    = 16'h00FF;
  localparam logic [DATA_W-1:0] ZERO16        = 16'h0000;
  localparam logic [DATA_W:0]   ONE17         = 17'h00001;
  localparam logic [DATA_W:0]   ZERO17        = 17'h00000;

  //----------------------------------------------------------------------------
  // Pointer set of dual-operand multiply-accumulate instructions
  //----------------------------------------------------------------------------
  localparam logic [1:0]        MAC_PTR_HI = 2'h2;
  localparam logic [SEL_W-1:0]  MAC_X_IDX  = 4'h9;
  localparam logic [SEL_W-1:0]  MAC_Y_IDX  = 4'hB;
  localparam logic [DATA_W-1:0] MAC_STEP2  = 16'h0002;
  localparam logic [DATA_W-1:0] MAC_STEP4  = 16'h0004;
  localparam logic [DATA_W-1:0] MAC_STEP6  = 16'h0006;

  //----------------------------------------------------------------------------
  // Addressing modes
  //----------------------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_INDIRECT = 3'b000,
    MODE_POSTMOD  = 3'b001,
    MODE_PREMOD   = 3'b010,
    MODE_REGOFF   = 3'b011,
    MODE_LITOFF   = 3'b100
  } agum_mode_t;

endpackage

// ---- agum_regfile_model.sv ----
// Purpose: Working register file that feeds pointers to the address generator
// Assumes: Write-back pulses come one cycle after each legal source post- or pre-modify request
// Notes  : The bench preloads pointers through the load port
`timescale 1ns/10ps
module agum_regfile_model (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RESET,
  // Pointer reads
  input  wire logic [3:0]  RD_SEL_A,
  input  wire logic [3:0]  RD_SEL_B,
  output logic      [15:0] RD_VAL_A,
  output logic      [15:0] RD_VAL_B,
  // Write-back and load
  input  wire logic        WB_EN,
  input  wire logic [3:0]  WB_SEL,
  input  wire logic [15:0] WB_VAL,
  input  wire logic        LOAD_EN,
  input  wire logic [3:0]  LOAD_SEL,
  input  wire logic [15:0] LOAD_VAL
);
  logic [15:0] regs [16];
  // Reads are combinational so the pointer is settled at the request edge
  assign RD_VAL_A = regs[RD_SEL_A];
  assign RD_VAL_B = regs[RD_SEL_B];
  // A load comes after write-back, so a fresh load always wins
  always_ff @(posedge CLK) begin
    if (RESET) begin
      for (int i = 0; i < 16; i++) regs[i] <= 16'h0000;
    end else begin
      if (WB_EN) regs[WB_SEL] <= WB_VAL;
      if (LOAD_EN) regs[LOAD_SEL] <= LOAD_VAL;
    end
  end
endmodule // agum_regfile_model

// ---- agum_modulo_addressing_test.sv ----
// Purpose: Self-checking bench comparing the generator with an integer model
// Assumes: Result latency of one cycle, read data one cycle after the strobe
// Notes  : Destination runs register-offset from a fixed pointer in register 12, except in the closing gd requests
`timescale 1ns/10ps
module agum_modulo_addressing_test;
  import agum_pkg::*;
  logic CLK = 0, RESET = 1, REG_WRITE = 0, REG_READ = 0, REQ = 0, MAC_CLASS = 0, SRC_Y_SPACE = 0, DST_WORD = 0;
  logic LOAD_EN = 0, DONE, SRC_SPACE_Y, SRC_WRAPPED, SRC_ILLEGAL, SRC_WB_EN, DST_WRAPPED, DST_BITREV, DST_WB_EN;
  logic [2:0] REG_ADDR = 0;
  logic [3:0] SRC_PTR_SEL = 0, DST_PTR_SEL = 4'hC, LOAD_SEL = 0, SRC_WB_SEL, DST_WB_SEL;
  logic [15:0] REG_WDATA = 0, OFFSET_VALUE = 0, SRC_MODIFIER = 0, DST_MODIFIER = 0, LOAD_VAL = 0, REG_RDATA;
  logic [15:0] SRC_PTR_VALUE, DST_PTR_VALUE, SRC_EA, SRC_WB_VALUE, DST_EA, DST_WB_VALUE;
  agum_mode_t SRC_MODE = MODE_INDIRECT, DST_MODE = MODE_REGOFF;
  int n_fail = 0, samples_checked = 0, n, c, y;
  int rm [8] = '{32'hFF, 0, 0, 0, 0, 0, 0, 0};
  int tb [5] = '{0, 32'h1000, 32'h101F, 32'h2000, 32'h2013};
  always #2 CLK = ~CLK;
  agum_core dut_u (.CLK(CLK), .RESET(RESET), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WRITE(REG_WRITE),
    .REG_READ(REG_READ), .REG_RDATA(REG_RDATA), .REQ(REQ), .MAC_CLASS(MAC_CLASS), .OFFSET_VALUE(OFFSET_VALUE),
    .SRC_Y_SPACE(SRC_Y_SPACE), .SRC_MODE(SRC_MODE), .SRC_PTR_SEL(SRC_PTR_SEL), .SRC_PTR_VALUE(SRC_PTR_VALUE),
    .SRC_MODIFIER(SRC_MODIFIER), .DST_MODE(DST_MODE), .DST_PTR_SEL(DST_PTR_SEL), .DST_PTR_VALUE(DST_PTR_VALUE),
    .DST_MODIFIER(DST_MODIFIER), .DST_WORD(DST_WORD), .DONE(DONE), .SRC_EA(SRC_EA), .SRC_SPACE_Y(SRC_SPACE_Y),
    .SRC_WRAPPED(SRC_WRAPPED), .SRC_ILLEGAL(SRC_ILLEGAL), .SRC_WB_EN(SRC_WB_EN), .SRC_WB_SEL(SRC_WB_SEL),
    .SRC_WB_VALUE(SRC_WB_VALUE), .DST_EA(DST_EA), .DST_WRAPPED(DST_WRAPPED), .DST_BITREV(DST_BITREV),
    .DST_WB_EN(DST_WB_EN), .DST_WB_SEL(DST_WB_SEL), .DST_WB_VALUE(DST_WB_VALUE));
  agum_regfile_model p_u (.CLK(CLK), .RESET(RESET), .RD_SEL_A(SRC_PTR_SEL), .RD_SEL_B(DST_PTR_SEL),
    .RD_VAL_A(SRC_PTR_VALUE), .RD_VAL_B(DST_PTR_VALUE), .WB_EN(SRC_WB_EN), .WB_SEL(SRC_WB_SEL),
    .WB_VAL(SRC_WB_VALUE), .LOAD_EN(LOAD_EN), .LOAD_SEL(LOAD_SEL), .LOAD_VAL(LOAD_VAL));
  // Case inequality so an unknown never counts as a match
  task automatic chk(input logic [16:0] seen, input logic [16:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge CLK);
    REG_WRITE <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    if (a < 6) rm[a] = d;
    @(posedge CLK);
    REG_WRITE <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge CLK);
    REG_READ <= 1'b1;
    REG_ADDR <= a;
    @(posedge CLK);
    REG_READ <= 1'b0;
    #1 chk(REG_RDATA, rm[a], "read");
  endtask
  // Model first, then load the pointer, request, and compare one cycle later
  task automatic go(input int mac, input agum_mode_t m, input int sel, input int p, input int md, input int off,
                    input int y);
    int s, st, e, len, ng, circ, w, ill, wb, yy;
    yy = mac ? sel / 2 % 2 : y;
    st = yy ? rm[3] : rm[1];
    e = yy ? rm[4] : rm[2];
    len = e - st + 1;
    ng = (m == MODE_REGOFF) ? off < 0 : md < 0;
    s = (p + ((m == MODE_REGOFF) ? off : md)) & 32'hFFFF;
    circ = m != MODE_INDIRECT && (yy ? rm[0][14] : rm[0][15]) && (yy ? rm[0][7:4] : rm[0][3:0]) == sel && sel != 15;
    w = circ && ((s > e && (!ng || (len & (len - 1)) == 0)) || (s < st && (ng || (len & (len - 1)) == 0)));
    if (w) s = (s > e) ? s - len : s + len;
    if (circ && yy) s = s & 32'hFFFE;
    ill = mac && (sel < 8 || sel > 11 || m == MODE_PREMOD || m == MODE_LITOFF || (m == MODE_REGOFF && sel % 2 == 0)
          || (m == MODE_POSTMOD && !(md inside {-6, -4, -2, 2, 4, 6})));
    wb = !ill && (m == MODE_POSTMOD || m == MODE_PREMOD);
    @(posedge CLK);
    LOAD_EN <= 1'b1;
    LOAD_SEL <= sel[3:0];
    LOAD_VAL <= p[15:0];
    @(posedge CLK);
    LOAD_EN <= 1'b0;
    REQ <= 1'b1;
    MAC_CLASS <= mac[0];
    SRC_Y_SPACE <= y[0];
    SRC_MODE <= m;
    SRC_PTR_SEL <= sel[3:0];
    SRC_MODIFIER <= md[15:0];
    OFFSET_VALUE <= off[15:0];
    @(posedge CLK);
    REQ <= 1'b0;
    #1 chk(DONE, 1, "done");
    chk(SRC_EA, m == MODE_INDIRECT ? p : m == MODE_POSTMOD ? p & (circ && yy ? 32'hFFFE : 32'hFFFF) : s,
        "source address");
    chk(SRC_WB_VALUE, m == MODE_INDIRECT ? p : s, "source new pointer");
    chk(SRC_WB_SEL, sel, "source write-back register");
    chk(SRC_WRAPPED, w, "wrap flag");
    chk(SRC_ILLEGAL, ill, "illegal flag");
    chk(SRC_WB_EN, wb, "write-back");
    chk(SRC_SPACE_Y, yy, "space");
    chk(DST_EA, (32'h3000 + off) & 32'hFFFF, "destination address");
    @(posedge CLK);
    #1 chk(p_u.regs[sel], wb ? s : p, "pointer after write-back");
  endtask
  // Add with the carry running from the top bit down, as a reversed modifier needs
  function automatic int radd(input int a, input int b);
    int r, cy, t;
    r = 0;
    cy = 0;
    for (int i = 15; i >= 0; i--) begin
      t = a[i] + b[i] + cy;
      r[i] = t[0];
      cy = t / 2;
    end
    return r;
  endfunction
  // Destination request on register 12; model covers reversal and upward X wrap
  task automatic gd(input agum_mode_t m, input int p, input int md, input int wd);
    int s, br, w;
    br = rm[5][15] && wd && (m == MODE_PREMOD || m == MODE_POSTMOD) && md >= 0;
    s = br ? radd(p, (rm[5] & 32'h7FFF) * 2) & 32'hFFFE : (p + md) & 32'hFFFF;
    w = !br && m != MODE_INDIRECT && rm[0][15] && rm[0][3:0] == 12 && s > rm[2];
    if (w) s = s - (rm[2] - rm[1] + 1);
    @(posedge CLK);
    LOAD_EN <= 1'b1;
    LOAD_SEL <= 4'hC;
    LOAD_VAL <= p[15:0];
    @(posedge CLK);
    LOAD_EN <= 1'b0;
    REQ <= 1'b1;
    DST_MODE <= m;
    DST_MODIFIER <= md[15:0];
    DST_WORD <= wd[0];
    @(posedge CLK);
    REQ <= 1'b0;
    #1 chk(DST_BITREV, br, "bit reverse flag");
    chk(DST_WB_VALUE, s, "destination new pointer");
    chk(DST_EA, m == MODE_POSTMOD ? p & (br ? 32'hFFFE : 32'hFFFF) : s, "destination address");
    chk(DST_WRAPPED, w, "destination wrap flag");
    chk(DST_WB_EN, m == MODE_PREMOD || m == MODE_POSTMOD, "destination write-back");
    chk(DST_WB_SEL, 12, "destination write-back register");
  endtask
  initial begin
    #40000;
    n_fail++;
    finish_test();
  end
  // Registers, then directed corners, then a random sweep of all modes
  initial begin
    n = $urandom(32'h31268AF3);
    repeat (10) @(posedge CLK);
    RESET <= 1'b0;
    rd(3'h0);
    wr(3'h6, 16'h1234);
    rd(3'h6);
    wr(3'h5, 16'h8001);
    rd(3'h5);
    wr(3'h5, 16'h0000);
    for (int i = 1; i < 5; i++) wr(i[2:0], tb[i][15:0]);
    for (int i = 1; i < 5; i++) rd(i[2:0]);
    @(posedge CLK);
    LOAD_EN <= 1'b1;
    LOAD_SEL <= 4'hC;
    LOAD_VAL <= 16'h3000;
    wr(3'h0, 16'h8002);
    go(0, MODE_PREMOD, 2, 32'h101E, 2, 0, 0);
    go(0, MODE_POSTMOD, 2, 32'h101C, 6, 0, 0);
    go(0, MODE_REGOFF, 2, 32'h101E, 0, 4, 0);
    go(0, MODE_LITOFF, 2, 32'h1010, 32'h20, 0, 0);
    go(0, MODE_PREMOD, 2, 32'h1000, -2, 0, 0);
    go(0, MODE_PREMOD, 15, 32'h101E, 2, 0, 0);
    wr(3'h0, 16'h0002);
    go(0, MODE_PREMOD, 2, 32'h101E, 2, 0, 0);
    wr(3'h0, 16'h4030);
    go(0, MODE_PREMOD, 3, 32'h2012, 4, 0, 1);
    go(0, MODE_PREMOD, 3, 32'h1FF0, 2, 0, 1);
    go(0, MODE_PREMOD, 3, 32'h2000, -2, 0, 1);
    go(0, MODE_PREMOD, 3, 32'h2003, 2, 0, 1);
    go(0, MODE_POSTMOD, 3, 32'h2013, 2, 0, 1);
    go(1, MODE_POSTMOD, 5, 32'h1000, 2, 0, 0);
    go(1, MODE_REGOFF, 8, 32'h1000, 0, 2, 0);
    go(1, MODE_REGOFF, 11, 32'h2000, 0, 2, 0);
    go(1, MODE_POSTMOD, 10, 32'h2000, 8, 0, 0);
    go(1, MODE_POSTMOD, 9, 32'h1000, -4, 0, 0);
    go(1, MODE_INDIRECT, 8, 32'h1000, 0, 0, 0);
    for (int i = 0; i < 60; i++) begin
      c = ($urandom & 32'hC000) | ($urandom % 4 * 16) | ($urandom % 4);
      y = $urandom % 2;
      wr(3'h0, c[15:0]);
      go(0, agum_mode_t'($urandom % 5), $urandom % 4, (y ? 32'h2000 : 32'h1000) - 8 + $urandom % 24 * 2,
         $urandom % 17 * 2 - 16, $urandom % 17 * 2 - 16, y);
    end
    wr(3'h0, 16'h800C);
    wr(3'h5, 16'h8008);
    gd(MODE_PREMOD, 32'h3000, 2, 1);
    gd(MODE_POSTMOD, 32'h3011, 2, 1);
    gd(MODE_PREMOD, 32'h3000, 2, 0);
    finish_test();
  end
endmodule // agum_modulo_addressing_test
